// *** verilog/sapc_consts.svh ***
// Port addresses, field positions and timing counts for the converter
// control block. Assumes the includer also imports sapc_pkg where needed.
`ifndef SAPC_CONSTS_SVH
`define SAPC_CONSTS_SVH

// Port addresses as seen by the processor port instructions
`define SAPC_ADDR_CHAN_SEL 5'h12
`define SAPC_ADDR_START 5'h13
`define SAPC_ADDR_RESULT 5'h0d
`define SAPC_ADDR_STATUS 5'h0c

// Field positions
`define SAPC_START_BIT_POS 1
`define SAPC_DONE_BIT_POS 3

// Reset values
`define SAPC_CHAN_SEL_RESET 4'h0
`define SAPC_RESULT_RESET 8'h00

// Conversion shape
`define SAPC_RESULT_WIDTH 8
`define SAPC_CONV_CYCLES 24
`define SAPC_STEPS_PER_BIT 3

// Instruction cycle timing
`define SAPC_CLK_PERIOD_NS 50
`define SAPC_INSTR_CYCLE_NS 1900
`define SAPC_CLKS_PER_INSTR \
	((`SAPC_INSTR_CYCLE_NS + `SAPC_CLK_PERIOD_NS - 1) / `SAPC_CLK_PERIOD_NS)

`endif

// *** verilog/sapc_pkg.sv ***
// Types shared by the converter control block modules.
// Assumes sapc_consts.svh is on the include path.
`include "sapc_consts.svh"

package sapc_pkg;

	// One processor port access, valid for one clock
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [3:0] wdata;
	} sapc_port_req_type;

	// Engine sequencing states
	typedef enum logic [0:0] {
		SAPC_IDLE,
		SAPC_CONVERT
	} sapc_conv_state_type;

endpackage

// *** verilog/sapc_cycle_divider.sv ***
// Instruction-cycle enable generator.
// Assumes a single free-running clock; emits one-clock enable pulses.
`timescale 1ns/1ps
`default_nettype none

module sapc_cycle_divider #(
	parameter int DIVIDE = 38
) (
	input wire logic clk,
	input wire logic reset_n,
	output logic instrEn
);
	import sapc_pkg::*;

	localparam int CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;

	// ****************************************
	// Elaboration check
	// ****************************************
	if (DIVIDE < 1) begin : g_bad_divide
		$error("sapc_cycle_divider: DIVIDE must be at least 1");
	end

	// Whole state of the divider
	typedef struct packed {
		logic [CW-1:0] count;
		logic pulse;
	} sapc_div_state_type;

	sapc_div_state_type s_q;
	sapc_div_state_type s_d;

	// Next-state: wrap the counter and pulse on wrap
	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (s_q.count == CW'(DIVIDE - 1)) begin
			s_d.count = '0;
			s_d.pulse = 1'b1;
		end else begin
			s_d.count = s_q.count + CW'(1);
		end
	end

	// Register the state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign instrEn = s_q.pulse;

endmodule

`default_nettype wire

// *** verilog/sapc_sar_engine.sv ***
// Successive-approximation sequencer: trial code out, comparator in.
// Assumes compHigh is already synchronised and means input >= trial code.
`timescale 1ns/1ps
`default_nettype none

module sapc_sar_engine #(
	parameter int WIDTH = 8,
	parameter int STEPS = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tickEn,
	input wire logic startReq,
	input wire logic compHigh,
	output logic busy,
	output logic donePulse,
	output logic [WIDTH-1:0] code,
	output logic [WIDTH-1:0] trialCode
);
	import sapc_pkg::*;

	localparam int BW = $clog2(WIDTH);
	localparam int PW = $clog2(STEPS);

	// ****************************************
	// Elaboration check
	// ****************************************
	if (STEPS < 3 || WIDTH < 2) begin : g_bad_shape
		$error("sapc_sar_engine: needs STEPS >= 3 and WIDTH >= 2");
	end

	// Whole state of the engine
	typedef struct packed {
		sapc_conv_state_type state;
		logic [BW-1:0] bitIdx;
		logic [PW-1:0] phase;
		logic [WIDTH-1:0] work;
		logic [WIDTH-1:0] result;
		logic done;
	} sapc_sar_state_type;

	sapc_sar_state_type s_q;
	sapc_sar_state_type s_d;

	// ****************************************
	// Sequencing
	// ****************************************
	// Each bit gets STEPS ticks: raise trial bit on the first, decide on
	// the last, so the comparator settles for STEPS-1 ticks.
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (startReq) begin
			// A start always wins, even mid-conversion
			s_d.state = SAPC_CONVERT;
			s_d.bitIdx = BW'(WIDTH - 1);
			s_d.phase = '0;
			s_d.work = '0;
		end else if (s_q.state == SAPC_CONVERT && tickEn) begin
			if (s_q.phase == '0) begin
				s_d.work[s_q.bitIdx] = 1'b1;
			end
			if (s_q.phase == PW'(STEPS - 1)) begin
				// Decide: drop the trial bit if input is below it
				if (!compHigh) begin
					s_d.work[s_q.bitIdx] = 1'b0;
				end
				s_d.phase = '0;
				if (s_q.bitIdx == '0) begin
					s_d.state = SAPC_IDLE;
					s_d.result = s_d.work;
					s_d.done = 1'b1;
				end else begin
					s_d.bitIdx = s_q.bitIdx - BW'(1);
				end
			end else begin
				s_d.phase = s_q.phase + PW'(1);
			end
		end
	end

	// Register the state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = (s_q.state == SAPC_CONVERT);
	assign donePulse = s_q.done;
	assign code = s_q.result;
	assign trialCode = s_q.work;

endmodule

`default_nettype wire

// *** verilog/sapc_port_control.sv ***
// Converter control block: port decode, command and status registers.
// Assumes the processor presents one-clock port strobes on clk and that
// the comparator level arrives asynchronously from the analog section.
//
// Summary of operation
// - Convert selected input to an 8-bit code
// - Selector and start live on output ports
// - Result and done flag on input ports
// - Writing start bit 1 begins a conversion
// - Start bit clears itself after starting
// - New start abandons conversion, restarts at once
// - Done flag sets 24 instruction cycles later
// - Done is one status bit, set when finished
// - Done clears on both nibbles read or start
// - Nibble select bit picks low or high nibble
// - Result read during conversion may be undefined
`include "sapc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sapc_port_control #(
	parameter int CLKS_PER_INSTR = `SAPC_CLKS_PER_INSTR,
	parameter int RESULT_WIDTH = `SAPC_RESULT_WIDTH
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire sapc_pkg::sapc_port_req_type portReq,
	input wire logic nibbleSelectBit,
	input wire logic compHighAsync,
	output logic [3:0] portRdata,
	output logic portRvalid,
	output logic [1:0] analogChannel,
	output logic [RESULT_WIDTH-1:0] trialCode,
	output logic converting
);
	import sapc_pkg::*;

	// ****************************************
	// Elaboration check
	// ****************************************
	// Two nibbles make the result; any other width breaks the port map
	if (RESULT_WIDTH != 8) begin : g_bad_width
		$error("sapc_port_control: RESULT_WIDTH must be 8");
	end
	// The comparator synchroniser needs two clocks inside each tick,
	// otherwise the decision reads the level of the previous trial code
	if (CLKS_PER_INSTR < 2) begin : g_bad_divide
		$error("sapc_port_control: CLKS_PER_INSTR must be at least 2");
	end

	// ****************************************
	// Submodules
	// ****************************************
	logic instrEn; // One pulse per instruction cycle
	logic engBusy; // Conversion in progress
	logic engDone; // One-clock completion pulse
	logic [RESULT_WIDTH-1:0] engCode; // Final code, valid with engDone

	// Whole state of this module
	typedef struct packed {
		logic [3:0] chanSel;
		logic startBit;
		logic [RESULT_WIDTH-1:0] result;
		logic doneFlag;
		logic lowRead;
		logic highRead;
		logic [3:0] rdata;
		logic rvalid;
		logic compMeta;
		logic compSync;
	} sapc_ctl_state_type;

	sapc_ctl_state_type s_q;
	sapc_ctl_state_type s_d;

	// Instruction-cycle enable from the fast clock
	sapc_cycle_divider #(
		.DIVIDE(CLKS_PER_INSTR)
	) u_div (
		.clk(clk),
		.reset_n(reset_n),
		.instrEn(instrEn)
	);

	// Bit sequencer; start comes from the self-clearing start bit
	sapc_sar_engine #(
		.WIDTH(RESULT_WIDTH),
		.STEPS(`SAPC_STEPS_PER_BIT)
	) u_sar (
		.clk(clk),
		.reset_n(reset_n),
		.tickEn(instrEn),
		.startReq(s_q.startBit),
		.compHigh(s_q.compSync),
		.busy(engBusy),
		.donePulse(engDone),
		.code(engCode),
		.trialCode(trialCode)
	);

	// ****************************************
	// Port decode
	// ****************************************
	logic wrChan; // Write to the channel selector port
	logic wrStart; // Write to the start command port
	logic rdResult; // Read of the result port
	logic rdStatus; // Read of the status port

	always_comb begin
		wrChan = portReq.wr && (portReq.addr == `SAPC_ADDR_CHAN_SEL);
		wrStart = portReq.wr && (portReq.addr == `SAPC_ADDR_START);
		rdResult = portReq.rd && (portReq.addr == `SAPC_ADDR_RESULT);
		rdStatus = portReq.rd && (portReq.addr == `SAPC_ADDR_STATUS);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		// Comparator level crosses in; only compMeta feeds compSync
		s_d.compMeta = compHighAsync;
		s_d.compSync = s_q.compMeta;

		// Selector keeps all four bits; the low two pick the input
		if (wrChan) begin
			s_d.chanSel = portReq.wdata;
		end

		// Start bit is a one-clock request; hardware drops it
		s_d.startBit = 1'b0;
		if (wrStart && portReq.wdata[`SAPC_START_BIT_POS]) begin
			s_d.startBit = 1'b1;
		end

		// Result holds between completions, also through a restart
		if (engDone) begin
			s_d.result = engCode;
		end

		// Read data: one registered answer per read strobe
		s_d.rvalid = portReq.rd;
		s_d.rdata = 4'h0;
		if (rdResult) begin
			// Mid-conversion reads return the held code, which is allowed
			if (nibbleSelectBit) begin
				s_d.rdata = s_q.result[7:4];
			end else begin
				s_d.rdata = s_q.result[3:0];
			end
		end else if (rdStatus) begin
			s_d.rdata[`SAPC_DONE_BIT_POS] = s_q.doneFlag;
		end

		// Track which halves were fetched since the last completion
		if (rdResult && s_q.doneFlag) begin
			if (nibbleSelectBit) begin
				s_d.highRead = 1'b1;
			end else begin
				s_d.lowRead = 1'b1;
			end
		end

		// Clears first, so a completion in the same clock wins
		if (s_q.startBit) begin
			s_d.doneFlag = 1'b0;
			s_d.lowRead = 1'b0;
			s_d.highRead = 1'b0;
		end else if (s_d.lowRead && s_d.highRead) begin
			s_d.doneFlag = 1'b0;
			s_d.lowRead = 1'b0;
			s_d.highRead = 1'b0;
		end
		if (engDone) begin
			s_d.doneFlag = 1'b1;
			s_d.lowRead = 1'b0;
			s_d.highRead = 1'b0;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.chanSel <= `SAPC_CHAN_SEL_RESET;
			s_q.result <= `SAPC_RESULT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign portRdata = s_q.rdata;
	assign portRvalid = s_q.rvalid;
	assign analogChannel = s_q.chanSel[1:0];
	assign converting = engBusy;

	// ****************************************
	// Checks
	// ****************************************
	// Counts instruction ticks since the last start, for the length check
	logic [5:0] tickCount;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tickCount <= 6'h00;
		end else if (s_q.startBit) begin
			tickCount <= 6'h00;
		end else if (engBusy && instrEn) begin
			tickCount <= tickCount + 6'h01;
		end
	end

	property p_start_sets;
		@(posedge clk) disable iff (!reset_n)
		(wrStart && portReq.wdata[`SAPC_START_BIT_POS]) |=> s_q.startBit;
	endproperty
	a_start_sets: assert property (p_start_sets)
		else $error("start write did not raise start bit");

	property p_start_clears;
		@(posedge clk) disable iff (!reset_n)
		(s_q.startBit && !(wrStart && portReq.wdata[`SAPC_START_BIT_POS]))
			|=> !s_q.startBit;
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("start bit did not clear itself");

	property p_restart;
		@(posedge clk) disable iff (!reset_n)
		s_q.startBit |=> (engBusy && !engDone)[*2];
	endproperty
	a_restart: assert property (p_restart)
		else $error("start did not (re)launch conversion");

	property p_length;
		@(posedge clk) disable iff (!reset_n)
		engDone |-> (tickCount == 6'd24);
	endproperty
	a_length: assert property (p_length)
		else $error("conversion length is not 24 cycles");

	property p_done_sets;
		@(posedge clk) disable iff (!reset_n)
		engDone |=> (s_q.doneFlag && s_q.result == $past(engCode));
	endproperty
	a_done_sets: assert property (p_done_sets)
		else $error("completion did not set flag and result");

	property p_done_clears_start;
		@(posedge clk) disable iff (!reset_n)
		(s_q.startBit && !engDone) |=> !s_q.doneFlag;
	endproperty
	a_done_clears_start: assert property (p_done_clears_start)
		else $error("start did not clear done flag");

	property p_result_hold;
		@(posedge clk) disable iff (!reset_n)
		!engDone |=> $stable(s_q.result);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("result changed without completion");

	property p_nibble;
		@(posedge clk) disable iff (!reset_n)
		rdResult |=> (portRvalid && portRdata == ($past(nibbleSelectBit) ?
			$past(s_q.result[7:4]) : $past(s_q.result[3:0])));
	endproperty
	a_nibble: assert property (p_nibble)
		else $error("wrong result nibble returned");

	property p_status;
		@(posedge clk) disable iff (!reset_n)
		rdStatus |=> (portRdata == {$past(s_q.doneFlag), 3'b000});
	endproperty
	a_status: assert property (p_status)
		else $error("status read does not show done flag");

	property p_both_read;
		@(posedge clk) disable iff (!reset_n)
		(rdResult && s_q.doneFlag && !engDone &&
			(nibbleSelectBit ? s_q.lowRead : s_q.highRead)) |=>
			!s_q.doneFlag;
	endproperty
	a_both_read: assert property (p_both_read)
		else $error("done flag stayed after both nibbles read");

endmodule

`default_nettype wire

// *** testbench/sapc_analog_model.sv ***
// Analog side stand-in: one level per input pin.
// Assumes levels are ideal codes; no noise or settling.
`timescale 1ns/1ps
`default_nettype none

module sapc_analog_model (
	input wire logic [1:0] analogChannel,
	input wire logic [7:0] trialCode,
	input wire logic [3:0][7:0] levels,
	output logic compHigh
);
	// ************
	// Comparator
	// ************
	// Pin is floated, so its level reaches the ladder
	always_comb begin
		compHigh = (levels[analogChannel] >= trialCode);
	end
endmodule
`default_nettype wire

// *** testbench/sar_adc_port_control_test.sv ***
// Bench: port accesses, a reference model and comparisons.
// Assumes the design files and sapc_analog_model are compiled first.
`include "sapc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sar_adc_port_control_test;
	import sapc_pkg::*;
	// ************
	// Signals
	// ************
	localparam int K = 2; // Short instruction cycle
	localparam int CONV = 24 * K; // Conversion in clocks
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	sapc_port_req_type portReq = '0;
	logic nibbleSelectBit = 1'b0;
	logic compHighAsync;
	logic [3:0] portRdata;
	logic portRvalid;
	logic [1:0] analogChannel;
	logic [7:0] trialCode;
	logic converting;
	logic [3:0][7:0] levels = '0; // Level per pin
	int num_errors = 0;
	int checks = 0;
	int expResult = 0; // Model of held code
	int cyc = 0;

	sapc_port_control #(.CLKS_PER_INSTR(K)) DUT (
		.clk(clk),
		.reset_n(reset_n),
		.portReq(portReq),
		.nibbleSelectBit(nibbleSelectBit),
		.compHighAsync(compHighAsync),
		.portRdata(portRdata),
		.portRvalid(portRvalid),
		.analogChannel(analogChannel),
		.trialCode(trialCode),
		.converting(converting)
	);
	sapc_analog_model analog (
		.analogChannel(analogChannel),
		.trialCode(trialCode),
		.levels(levels),
		.compHigh(compHighAsync)
	);

	// Clock and edge count
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end

	// ************
	// Tasks
	// ************
	task automatic checkNib(input logic [3:0] g, input logic [3:0] e,
		input string m);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: %s %h/%h", $time, m, g, e);
		end
	endtask
	task automatic checkFlag(input logic g, input logic e, input string m);
		checkNib({3'b000, g}, {3'b000, e}, m);
	endtask
	// Strobe held one edge, released at the next fall
	task automatic portWrite(input logic [4:0] a, input logic [3:0] d);
		@(negedge clk);
		portReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		portReq = '0;
	endtask
	task automatic portRead(input logic [4:0] a, input logic s,
		output logic [3:0] d);
		int n;
		@(negedge clk);
		portReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
		nibbleSelectBit = s;
		@(negedge clk);
		portReq = '0;
		n = 0;
		while (portRvalid !== 1'b1 && n < 3) begin
			@(negedge clk);
			n++;
		end
		checkFlag(portRvalid, 1'b1, "read answer");
		d = portRdata;
	endtask
	task automatic readResult(input int e);
		logic [3:0] d;
		portRead(`SAPC_ADDR_RESULT, 1'b0, d);
		checkNib(d, e[3:0], "low nibble");
		portRead(`SAPC_ADDR_STATUS, 1'b0, d);
		checkNib(d, 4'h8, "done after one nibble");
		portRead(`SAPC_ADDR_RESULT, 1'b1, d);
		checkNib(d, e[7:4], "high nibble");
		portRead(`SAPC_ADDR_STATUS, 1'b0, d);
		checkNib(d, 4'h0, "done after both");
	endtask
	// Select, start, optionally restart, wait and poll
	task automatic runConv(input logic [1:0] ch, input int abortAt);
		int t0;
		logic [3:0] d;
		portWrite(`SAPC_ADDR_CHAN_SEL, {2'b00, ch});
		checkNib({2'b00, analogChannel}, {2'b00, ch}, "channel");
		portWrite(`SAPC_ADDR_START, 4'h2);
		if (abortAt > 0) begin
			repeat (abortAt) @(negedge clk);
			portRead(`SAPC_ADDR_RESULT, 1'b0, d);
			checkNib(d, expResult[3:0], "held mid-run");
			levels[ch] = 8'($urandom);
			portWrite(`SAPC_ADDR_START, 4'h2);
		end
		repeat (2) @(negedge clk);
		t0 = cyc;
		checkFlag(converting, 1'b1, "converting");
		portRead(`SAPC_ADDR_STATUS, 1'b0, d);
		checkNib(d, 4'h0, "done cleared by start");
		while (converting === 1'b1 && cyc - t0 < CONV + 10) begin
			// Port stays idle while converting; writes disturb the ladder
			@(negedge clk);
		end
		checkFlag(cyc - t0 >= CONV - K && cyc - t0 <= CONV + K, 1'b1,
			"length");
		portRead(`SAPC_ADDR_STATUS, 1'b0, d);
		checkNib(d, 4'h8, "done flag");
		expResult = levels[ch];
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ************
	// Sequence
	// ************
	initial begin
		logic [3:0] d;
		void'($urandom(32'hb25d));
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		// Reset state, unmapped and write-only reads
		portRead(`SAPC_ADDR_STATUS, 1'b0, d);
		checkNib(d, 4'h0, "reset status");
		portRead(`SAPC_ADDR_RESULT, 1'b1, d);
		checkNib(d, 4'h0, "reset result");
		portRead(5'h05, 1'b0, d);
		checkNib(d, 4'h0, "unmapped");
		portRead(`SAPC_ADDR_CHAN_SEL, 1'b0, d);
		checkNib(d, 4'h0, "write-only");
		$display("Test reset done");
		for (int c = 0; c < 4; c++) begin
			levels[c] = 8'($urandom);
		end
		levels[1] = 8'hff; // Top code
		levels[2] = 8'h00; // Bottom code
		runConv(2'd0, 0);
		readResult(expResult);
		$display("Test channel 0 done");
		runConv(2'd1, 0);
		portRead(`SAPC_ADDR_RESULT, 1'b1, d);
		checkNib(d, expResult[7:4], "high only");
		portRead(`SAPC_ADDR_STATUS, 1'b0, d);
		checkNib(d, 4'h8, "single nibble keeps done");
		$display("Test channel 1 done");
		// Start with done still set must clear it
		runConv(2'd2, 0);
		readResult(expResult);
		$display("Test channel 2 done");
		runConv(2'd3, 7);
		readResult(expResult);
		$display("Test restart done");
		// Start bit clear: nothing begins
		portWrite(`SAPC_ADDR_START, 4'hd);
		repeat (3) @(negedge clk);
		checkFlag(converting, 1'b0, "no start");
		$display("Test idle write done");
		conclude();
	end

	// Watchdog
	initial begin
		#(50 * 20000);
		num_errors++;
		$display("Error at %0t: watchdog expired", $time);
		conclude();
	end
endmodule
`default_nettype wire
